// ### design/sawl_link.sv
// serial audio word link: bit clock, word select and serial data, master or slave
// assumes tx_pair_i and control inputs are on clock_i; sck, ws and data pins are async

module sawl_link #(
  parameter int SYS_BITS = sawl_pkg::SYS_BITS,
  parameter int HALF_CYC = sawl_pkg::SCK_HALF_CYC
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic audio_interface_select_i,
  input wire logic master_i,
  input wire logic hd_transmit_i,
  input wire sawl_pkg::sawl_pair_t tx_pair_i,
  input wire logic sck_i,
  input wire logic ws_i,
  input wire logic sdi_i,
  input wire logic sdio_i,
  output logic sck_o,
  output logic sck_oe_n_o,
  output logic ws_o,
  output logic ws_oe_n_o,
  output logic sdo_o,
  output logic sdio_o,
  output logic sdio_oe_n_o,
  output sawl_pkg::sawl_word_t rx_word_o,
  output logic rx_valid_o
);
  import sawl_pkg::*;

  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(SYS_BITS - 1);
  localparam logic [CNT_W-1:0] WORD_LEN = CNT_W'(WORD_W);
  localparam logic [CNT_W-1:0] WORD_TOP = CNT_W'(WORD_W - 1);

  // pin synchronisers; first stage feeds only the second
  logic sck_m0, sck_m1, sck_d;
  logic ws_m0, ws_m1;
  logic sd_m0, sd_m1;
  logic sd_pin;

  // bit clock and word select generation for master role
  logic [CNT_W-1:0] div_cnt, next_div_cnt;
  logic [CNT_W-1:0] frame_cnt, next_frame_cnt;
  logic sck_r, next_sck_r;
  logic ws_r, next_ws_r;
  logic rise, fall, ws_now, ws_chg;

  // frame state
  logic ws_seen, next_ws_seen;
  logic load_pend, next_load_pend;
  logic [WORD_W-1:0] rx_acc, next_rx_acc;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic [WORD_W-1:0] tx_sh, next_tx_sh;
  logic [CNT_W-1:0] tx_cnt, next_tx_cnt;
  logic sd_out, next_sd_out;
  sawl_word_t rx_word, next_rx_word;
  logic rx_valid, next_rx_valid;
  logic role_oe_n, hd_oe_n;

  // shared pin in half-duplex, separate input pin otherwise
  assign sd_pin = audio_interface_select_i ? sdio_i : sdi_i;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_m0 <= 1'b0;
      sck_m1 <= 1'b0;
      sck_d <= 1'b0;
      ws_m0 <= 1'b0;
      ws_m1 <= 1'b0;
      sd_m0 <= 1'b0;
      sd_m1 <= 1'b0;
    end else begin
      sck_m0 <= sck_i;
      sck_m1 <= sck_m0;
      sck_d <= sck_m1;
      ws_m0 <= ws_i;
      ws_m1 <= ws_m0;
      sd_m0 <= sd_pin;
      sd_m1 <= sd_m0;
    end
  end

  always_comb begin
    next_div_cnt = div_cnt + CNT_ONE;
    next_sck_r = sck_r;
    next_ws_r = ws_r;
    next_frame_cnt = frame_cnt;
    if (div_cnt == HALF_LAST) begin
      next_div_cnt = CNT_ZERO;
      next_sck_r = !sck_r;
    end
    // word select moves on a falling edge; channel lengths are equal here by choice
    if (master_i && fall) begin
      if (frame_cnt == FRAME_LAST) begin
        next_frame_cnt = CNT_ZERO;
        next_ws_r = !ws_r;
      end else begin
        next_frame_cnt = frame_cnt + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= CNT_ZERO;
      frame_cnt <= CNT_ZERO;
      sck_r <= 1'b0;
      ws_r <= WS_LEFT;
    end else begin
      div_cnt <= next_div_cnt;
      frame_cnt <= next_frame_cnt;
      sck_r <= next_sck_r;
      ws_r <= next_ws_r;
    end
  end

  // edges come from our own divider as master, from the synced pin as slave
  always_comb begin
    if (master_i) begin
      rise = (div_cnt == HALF_LAST) && !sck_r;
      fall = (div_cnt == HALF_LAST) && sck_r;
      ws_now = ws_r;
    end else begin
      rise = sck_m1 && !sck_d;
      fall = !sck_m1 && sck_d;
      ws_now = ws_m1;
    end
    ws_chg = ws_now != ws_seen;
  end

  always_comb begin
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] word;
    logic [CNT_W-1:0] idx;
    acc = rx_acc;
    word = (ws_seen == WS_RIGHT) ? tx_pair_i.right : tx_pair_i.left;
    idx = WORD_TOP - rx_cnt;
    next_ws_seen = ws_seen;
    next_load_pend = load_pend;
    next_rx_acc = rx_acc;
    next_rx_cnt = rx_cnt;
    next_rx_word = rx_word;
    next_rx_valid = 1'b0;
    next_tx_sh = tx_sh;
    next_tx_cnt = tx_cnt;
    next_sd_out = sd_out;
    if (rise) begin
      // bits past our word length are dropped; unfilled ones stay zero
      if (rx_cnt < WORD_LEN) begin
        acc[idx[$clog2(WORD_W)-1:0]] = sd_m1;
        next_rx_cnt = rx_cnt + CNT_ONE;
      end
      next_rx_acc = acc;
      if (ws_chg) begin
        next_rx_word.data = acc;
        next_rx_word.right = ws_seen;
        next_rx_valid = 1'b1;
        next_rx_acc = '0;
        next_rx_cnt = CNT_ZERO;
        next_ws_seen = ws_now;
        next_load_pend = 1'b1;
      end
    end
    if (fall) begin
      // load on the first falling edge after the select change seen on a rising edge
      if (load_pend) begin
        next_sd_out = word[WORD_W-1];
        next_tx_sh = {word[WORD_W-2:0], 1'b0};
        next_tx_cnt = CNT_ONE;
        next_load_pend = 1'b0;
      end else begin
        // zeros shift in behind the word to pad longer system slots
        next_sd_out = tx_sh[WORD_W-1];
        next_tx_sh = {tx_sh[WORD_W-2:0], 1'b0};
        if (tx_cnt != '1) begin
          next_tx_cnt = tx_cnt + CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ws_seen <= WS_LEFT;
      load_pend <= 1'b0;
      rx_acc <= '0;
      rx_cnt <= CNT_ZERO;
      rx_word <= '0;
      rx_valid <= 1'b0;
      tx_sh <= '0;
      tx_cnt <= CNT_ZERO;
      sd_out <= 1'b0;
      role_oe_n <= 1'b1;
      hd_oe_n <= 1'b1;
    end else begin
      ws_seen <= next_ws_seen;
      load_pend <= next_load_pend;
      rx_acc <= next_rx_acc;
      rx_cnt <= next_rx_cnt;
      rx_word <= next_rx_word;
      rx_valid <= next_rx_valid;
      tx_sh <= next_tx_sh;
      tx_cnt <= next_tx_cnt;
      sd_out <= next_sd_out;
      role_oe_n <= !master_i;
      hd_oe_n <= !(audio_interface_select_i && hd_transmit_i);
    end
  end

  assign sck_o = sck_r;
  assign ws_o = ws_r;
  assign sck_oe_n_o = role_oe_n;
  assign ws_oe_n_o = role_oe_n;
  assign sdo_o = sd_out;
  assign sdio_o = sd_out;
  assign sdio_oe_n_o = hd_oe_n;
  assign rx_word_o = rx_word;
  assign rx_valid_o = rx_valid;

  AST_HD_DRIVE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    !sdio_oe_n_o |-> $past(audio_interface_select_i) && $past(hd_transmit_i))
    else $error("shared pin driven while not transmitting");

  AST_RX_STORE: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (rise && ws_chg) |=> rx_valid_o && (rx_cnt == CNT_ZERO) && (rx_acc == '0))
    else $error("word not stored or input not cleared on select change");

  AST_RX_CHANNEL: assert property (@(posedge clock_i) disable iff (!nrst_i)
    rx_valid_o |-> (rx_word_o.right != ws_seen))
    else $error("stored word has wrong channel");

  AST_RX_DISCARD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (rise && !ws_chg && rx_cnt >= WORD_LEN) |=> $stable(rx_acc))
    else $error("bit beyond word length was kept");

  AST_RX_RISE_ONLY: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $changed(rx_acc) |-> $past(rise))
    else $error("receive register changed off a rising edge");

  // half a bit period is well under 40 cycles at any supported bit clock
  AST_MSB_AFTER_WS: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (rise && ws_chg) |-> ##[1:40] (fall && load_pend))
    else $error("no falling edge loads the msb after select change");

  AST_MSB_LOAD: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (fall && load_pend) |=> (tx_cnt == CNT_ONE) && !load_pend &&
      (sdo_o == ($past(ws_seen) ? $past(tx_pair_i.right[WORD_W-1]) : $past(tx_pair_i.left[WORD_W-1]))))
    else $error("msb not sent on the edge after select change");

  AST_ZERO_FILL: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (fall && !load_pend && tx_cnt >= WORD_LEN) |=> !sdo_o)
    else $error("non-zero fill after word end");

  AST_TX_FALL_ONLY: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $changed(sdo_o) |-> $past(fall))
    else $error("data changed off a falling edge");

  AST_MASTER_WS: assert property (@(posedge clock_i) disable iff (!nrst_i)
    $changed(ws_o) |-> $past(fall) && $past(master_i) && ($past(frame_cnt) == FRAME_LAST))
    else $error("word select moved at wrong time");
endmodule

// ### design/sawl_pkg.sv
// constants and carrier types for the serial audio word link
// assumes a single 200 MHz core clock; all link pins are asynchronous to it
package sawl_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int WORD_W = 16;
  localparam int SYS_BITS = 32;
  localparam int SCK_PERIOD_NS = 64;
  // longest half period, rounded down, never below one cycle
  localparam int SCK_HALF_RAW = (SCK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYC = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;
  localparam int CNT_W = 8;
  localparam logic WS_LEFT = 1'b0;
  localparam logic WS_RIGHT = 1'b1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef struct packed {
    logic [WORD_W-1:0] left;
    logic [WORD_W-1:0] right;
  } sawl_pair_t;

  typedef struct packed {
    logic right;
    logic [WORD_W-1:0] data;
  } sawl_word_t;
endpackage

// ### test/sawl_far_end.sv
// far-end link master: free-running bit clock, word select, 24-bit words
// assumes dev_sd_i is the device's data as seen on the wire
module sawl_far_end (
  input wire logic [5:0] slot_i,
  input wire logic [23:0] send_l_i,
  input wire logic [23:0] send_r_i,
  input wire logic dev_sd_i,
  output logic sck_o,
  output logic ws_o,
  output logic sd_o,
  output logic [23:0] got_l_o,
  output logic [23:0] got_r_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] w;
  logic [23:0] g;
  int n;
  initial begin
    sck_o = 1'b1;
    ws_o = 1'b0;
    sd_o = 1'b0;
    got_l_o = 24'h000000;
    got_r_o = 24'h000000;
    // clock never stops, so the model is always master
    forever begin
      for (int c = 0; c < 2; c++) begin
        w = c ? send_r_i : send_l_i;
        n = slot_i;
        g = 24'h000000;
        for (int b = 0; b < n; b++) begin
          #32 sck_o = 1'b0;
          sd_o = (b < 24) ? w[23-b] : 1'b0;
          if (b == n - 1) ws_o = ~ws_o;
          #32 sck_o = 1'b1;
          if (b < 24) g[23-b] = dev_sd_i;
        end
        if (c == 0) got_l_o = g;
        else got_r_o = g;
      end
    end
  end
endmodule

// ### test/tb_top.sv
// self-checking bench for the serial audio word link
// assumes the far-end model drives the link; device as slave unless noted
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import sawl_pkg::*;
  logic clock_i, nrst_i, sel, master, hd_tx, f_sck, f_ws, f_sd, sck_o, sck_oe_n_o, ws_o, ws_oe_n_o;
  logic sdo_o, sdio_o, sdio_oe_n_o, rx_valid_o, sdio_line, dev_sd;
  logic [5:0] slot;
  logic [23:0] got_l, got_r;
  logic [15:0] lgot, rgot;
  sawl_pair_t tx_pair;
  sawl_word_t rx_word_o;
  int words, failures, checked;
  assign sdio_line = sdio_oe_n_o ? f_sd : sdio_o;
  assign dev_sd = sel ? sdio_line : sdo_o;
  sawl_link dut (.clock_i(clock_i), .nrst_i(nrst_i), .audio_interface_select_i(sel), .master_i(master),
    .hd_transmit_i(hd_tx), .tx_pair_i(tx_pair), .sck_i(f_sck), .ws_i(f_ws), .sdi_i(f_sd),
    .sdio_i(sdio_line), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o), .ws_o(ws_o), .ws_oe_n_o(ws_oe_n_o),
    .sdo_o(sdo_o), .sdio_o(sdio_o), .sdio_oe_n_o(sdio_oe_n_o), .rx_word_o(rx_word_o),
    .rx_valid_o(rx_valid_o));
  sawl_far_end far (.slot_i(slot), .send_l_i(24'h812345), .send_r_i(24'h6E5D4C), .dev_sd_i(dev_sd),
    .sck_o(f_sck), .ws_o(f_ws), .sd_o(f_sd), .got_l_o(got_l), .got_r_o(got_r));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // sampled mid-cycle so the one-cycle pulse is seen exactly once
  always @(negedge clock_i) begin
    if (rx_valid_o === 1'b1) begin
      words++;
      if (rx_word_o.right) rgot = rx_word_o.data;
      else lgot = rx_word_o.data;
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // five words so at least one full frame follows any mode change
  task automatic check_words(input logic [15:0] el, er, input logic [23:0] fl, fr, input string s);
    int k;
    k = words;
    for (int t = 0; t < 40000 && words < k + 5; t++) @(posedge clock_i);
    if (words < k + 5) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, words, k + 5);
      close_out;
    end else begin
      cmp(lgot, el);
      cmp(rgot, er);
      cmp(got_l, fl);
      cmp(got_r, fr);
      $display("[END] %s", s);
    end
  endtask
  task automatic t_master;
    int ch, rises;
    logic pw, ps;
    @(negedge clock_i) master = 1'b1;
    ch = 0;
    rises = 0;
    pw = ws_o;
    ps = sck_o;
    for (int c = 0; c < 4000 && ch < 3; c++) begin
      @(negedge clock_i);
      if (sck_o && !ps && ch == 1) rises++;
      if (ws_o !== pw) ch++;
      pw = ws_o;
      ps = sck_o;
    end
    cmp(ch, 3);
    cmp(rises, SYS_BITS);
    cmp({sck_oe_n_o, ws_oe_n_o}, 2'b00);
    @(negedge clock_i) master = 1'b0;
    $display("[END] master");
  endtask
  initial begin
    {nrst_i, sel, master, hd_tx} = 4'h0;
    slot = 6'h20;
    tx_pair = '{left: 16'hC35A, right: 16'h1E87};
    repeat (20) @(negedge clock_i);
    nrst_i = 1'b1;
    check_words(16'h8123, 16'h6E5D, 24'hC35A00, 24'h1E8700, "long");
    @(negedge clock_i) slot = 6'h0C;
    check_words(16'h8120, 16'h6E50, 24'hC35000, 24'h1E8000, "short");
    @(negedge clock_i) slot = 6'h20;
    sel = 1'b1;
    repeat (3) @(negedge clock_i);
    cmp(sdio_oe_n_o, 1'b1);
    check_words(16'h8123, 16'h6E5D, 24'h812345, 24'h6E5D4C, "hd rx");
    @(negedge clock_i) hd_tx = 1'b1;
    repeat (3) @(negedge clock_i);
    cmp(sdio_oe_n_o, 1'b0);
    check_words(16'hC35A, 16'h1E87, 24'hC35A00, 24'h1E8700, "hd tx");
    @(negedge clock_i) {sel, hd_tx} = 2'b00;
    t_master();
    close_out;
  end
endmodule
